// file: hw/timer_pkg.sv
package timer_pkg;
	// Operation modes held in the two mode bits.
	typedef enum logic [1:0] {
		MODE_STOP      = 2'b00,
		MODE_FREE      = 2'b01,
		MODE_EDGE_CLR  = 2'b10,
		MODE_MATCH_CLR = 2'b11
	} op_mode_type;

	// Active edge selection for a trigger input.
	typedef enum logic [1:0] {
		EDGE_FALL = 2'b00,
		EDGE_RISE = 2'b01,
		EDGE_NONE = 2'b10,
		EDGE_BOTH = 2'b11
	} edge_sel_type;

	localparam logic [15:0] COUNT_MAX   = 16'hFFFF;
	localparam logic [15:0] COUNT_ZERO  = 16'h0000;
	localparam logic [15:0] COUNT_ONE   = 16'h0001;
	localparam logic [15:0] REG_RESET   = 16'h0000;
	localparam int          PRESC_WIDTH = 4;
	localparam logic [3:0]  PRESC_RESET = 4'h0;
	// Prescaler mode field positions: first edge, second edge, divider.
	localparam int          PRM_EDGE0_LSB = 0;
	localparam int          PRM_EDGE1_LSB = 2;
	localparam int          PRM_DIV_LSB   = 4;
	localparam int          PRM_WIDTH     = 8;
	localparam logic [7:0]  PRM_RESET     = 8'h00;
endpackage

// file: hw/edge_if.sv
// Carries the selected-edge events of the two trigger inputs.
interface edge_if;
	logic first_edge;
	logic second_edge;
	modport src (output first_edge, output second_edge);
	modport dst (input first_edge, input second_edge);
endinterface

// file: hw/trigger_edge_detect.sv
// Detects the selected edge on each trigger input.
module trigger_edge_detect (
	input  wire logic       clock,
	input  wire logic       srst,
	input  wire logic       running,
	input  wire logic [1:0] trig_in,
	input  wire logic [3:0] edge_sel,
	edge_if.src             ev
);
	logic [1:0] prev_r;
	logic [1:0] prev_nxt;
	logic [1:0] hit;

	// Edge evaluation per input; the previous level is tracked while stopped so a high pin at start is no edge.
	for (genvar i = 0; i < 2; i++) begin : g_edge
		always_comb begin
			unique case (timer_pkg::edge_sel_type'(edge_sel[2*i +: 2]))
				timer_pkg::EDGE_FALL: hit[i] = prev_r[i] & ~trig_in[i];
				timer_pkg::EDGE_RISE: hit[i] = ~prev_r[i] & trig_in[i];
				timer_pkg::EDGE_NONE: hit[i] = 1'b0;
				timer_pkg::EDGE_BOTH: hit[i] = prev_r[i] ^ trig_in[i];
			endcase
		end
	end

	// Next previous-level values.
	always_comb begin
		prev_nxt = trig_in;
	end

	// Register the previous levels.
	always_ff @(posedge clock) begin
		if (srst) begin
			prev_r <= 2'h0;
		end else begin
			prev_r <= prev_nxt;
		end
	end

	assign ev.first_edge  = hit[0] & running;
	assign ev.second_edge = hit[1] & running;
endmodule

// file: hw/timer_capture_compare_16bit.sv
module timer_capture_compare_16bit (
	input  wire logic        clock,
	input  wire logic        srst,
	input  wire logic [1:0]  mode_wdata,
	input  wire logic        mode_we,
	input  wire logic        overflow_clr,
	input  wire logic [1:0]  capture_ctrl_wdata,
	input  wire logic        capture_ctrl_we,
	input  wire logic [7:0]  prescaler_wdata,
	input  wire logic        prescaler_we,
	input  wire logic [15:0] cc_wdata,
	input  wire logic        first_cc_we,
	input  wire logic        second_cc_we,
	input  wire logic        one_shot_trig,
	input  wire logic        first_trigger_input,
	input  wire logic        second_trigger_input,
	output logic      [15:0] count_register,
	output logic      [15:0] first_capture_compare_reg,
	output logic      [15:0] second_capture_compare_reg,
	output logic      [1:0]  mode_control_reg,
	output logic             overflow_flag,
	output logic             first_match_irq,
	output logic             second_match_irq
);
	edge_if ev ();

	logic [15:0] cnt_r, cnt_nxt, cc0_r, cc0_nxt, cc1_r, cc1_nxt;
	logic [1:0]  mode_r, mode_nxt, crc_r, crc_nxt;
	logic [7:0]  prm_r, prm_nxt;
	logic [3:0]  div_r, div_nxt;
	logic        ovf_r, ovf_nxt, irq0_r, irq0_nxt, irq1_r, irq1_nxt, wrapped_r, wrapped_nxt;
	logic        running, tick, wrap, clr, m0, m1;

	assign running = (mode_r != timer_pkg::MODE_STOP);

	// Edge detection with selections from the prescaler mode register.
	trigger_edge_detect u_edge (
		.clock    (clock),
		.srst     (srst),
		.running  (running),
		.trig_in  ({second_trigger_input, first_trigger_input}),
		.edge_sel (prm_r[timer_pkg::PRM_EDGE1_LSB+1:timer_pkg::PRM_EDGE0_LSB]),
		.ev       (ev)
	);

	// Count clock ticks, match detection and the next state of every register.
	always_comb begin
		div_nxt = running ? div_r + 4'h1 : timer_pkg::PRESC_RESET;
		tick = running && (div_r >= prm_r[timer_pkg::PRM_DIV_LSB +: timer_pkg::PRESC_WIDTH]);
		if (tick) begin
			div_nxt = timer_pkg::PRESC_RESET;
		end
		wrap = tick && (cnt_r == timer_pkg::COUNT_MAX);
		// Zero compare values only match after a wrap, on the step to 0001H.
		m0 = tick && ((cc0_r == timer_pkg::COUNT_ZERO) ? (wrapped_r && cnt_r == timer_pkg::COUNT_ZERO)
			: (cnt_r == cc0_r));
		m1 = tick && ((cc1_r == timer_pkg::COUNT_ZERO) ? (wrapped_r && cnt_r == timer_pkg::COUNT_ZERO)
			: (cnt_r == cc1_r));
		clr = (mode_r == timer_pkg::MODE_MATCH_CLR && m0 && cc0_r != timer_pkg::COUNT_ZERO)
			|| (mode_r == timer_pkg::MODE_EDGE_CLR && ev.first_edge) || (running && one_shot_trig);
		cnt_nxt = cnt_r;
		if (!running) begin
			cnt_nxt = timer_pkg::COUNT_ZERO;
		end else if (clr) begin
			cnt_nxt = timer_pkg::COUNT_ZERO;
		end else if (tick) begin
			cnt_nxt = cnt_r + timer_pkg::COUNT_ONE;
		end
		wrapped_nxt = wrapped_r;
		if (wrap) begin
			wrapped_nxt = 1'b1;
		end else if (tick || !running) begin
			wrapped_nxt = 1'b0;
		end
		mode_nxt = mode_we ? mode_wdata : mode_r;
		crc_nxt  = capture_ctrl_we ? capture_ctrl_wdata : crc_r;
		prm_nxt  = prescaler_we ? prescaler_wdata : prm_r;
		// Captures take the live count so the stored value is right whatever a read sees.
		cc0_nxt = first_cc_we ? cc_wdata : cc0_r;
		if (crc_r[0] && ev.second_edge) begin
			cc0_nxt = cnt_r;
		end
		cc1_nxt = second_cc_we ? cc_wdata : cc1_r;
		if (crc_r[1] && ev.first_edge) begin
			cc1_nxt = cnt_r;
		end
		// Set wins over a software clear of the overflow flag.
		ovf_nxt = (ovf_r && !overflow_clr) || (wrap && cc0_r == timer_pkg::COUNT_MAX);
		irq0_nxt = m0 || (crc_r[0] && ev.second_edge) || (running && one_shot_trig);
		irq1_nxt = m1 || ev.first_edge || (running && one_shot_trig);
	end

	// Register every state element.
	always_ff @(posedge clock) begin
		if (srst) begin
			cnt_r     <= timer_pkg::REG_RESET;
			cc0_r     <= timer_pkg::REG_RESET;
			cc1_r     <= timer_pkg::REG_RESET;
			mode_r    <= timer_pkg::MODE_STOP;
			crc_r     <= 2'h0;
			prm_r     <= timer_pkg::PRM_RESET;
			div_r     <= timer_pkg::PRESC_RESET;
			ovf_r     <= 1'b0;
			irq0_r    <= 1'b0;
			irq1_r    <= 1'b0;
			wrapped_r <= 1'b0;
		end else begin
			cnt_r     <= cnt_nxt;
			cc0_r     <= cc0_nxt;
			cc1_r     <= cc1_nxt;
			mode_r    <= mode_nxt;
			crc_r     <= crc_nxt;
			prm_r     <= prm_nxt;
			div_r     <= div_nxt;
			ovf_r     <= ovf_nxt;
			irq0_r    <= irq0_nxt;
			irq1_r    <= irq1_nxt;
			wrapped_r <= wrapped_nxt;
		end
	end

	assign count_register             = cnt_r;
	assign first_capture_compare_reg  = cc0_r;
	assign second_capture_compare_reg = cc1_r;
	assign mode_control_reg           = mode_r;
	assign overflow_flag              = ovf_r;
	assign first_match_irq            = irq0_r;
	assign second_match_irq           = irq1_r;

	// Longest gap between two count ticks, set by the widest divider field.
	localparam int TICK_GAP_MAX = 2 ** timer_pkg::PRESC_WIDTH;

	// A count tick that takes the counter from FFFFH over to 0000H.
	sequence wrap_seq;
		wrap;
	endsequence

	// The tick that leaves 0000H after a wrap, with the second register at zero.
	sequence second_zero_step_seq;
		tick && wrapped_r && cnt_r == timer_pkg::COUNT_ZERO && cc1_r == timer_pkg::COUNT_ZERO;
	endsequence

	// The same step with the first register at zero.
	sequence first_zero_step_seq;
		tick && wrapped_r && cnt_r == timer_pkg::COUNT_ZERO && cc0_r == timer_pkg::COUNT_ZERO;
	endsequence

	AST_STOP_CLEARS: assert property (@(posedge clock) disable iff (srst)
		!running |=> cnt_r == timer_pkg::COUNT_ZERO) else $error("Counter not cleared while stopped.");
	AST_INCREMENT: assert property (@(posedge clock) disable iff (srst)
		(tick && !clr && !mode_we) |=> cnt_r == $past(cnt_r) + timer_pkg::COUNT_ONE)
		else $error("Counter did not step by one.");
	AST_OVF_SET: assert property (@(posedge clock) disable iff (srst)
		(wrap && cc0_r == timer_pkg::COUNT_MAX) |=> ovf_r) else $error("Overflow flag not set on wrap.");
	AST_IRQ1_ZERO: assert property (@(posedge clock) disable iff (srst)
		wrap_seq ##[1:TICK_GAP_MAX] second_zero_step_seq |=> irq1_r)
		else $error("Second interrupt missing after wrap.");
	AST_IRQ1_NOT_AT_WRAP: assert property (@(posedge clock) disable iff (srst)
		(wrap && cc1_r == timer_pkg::COUNT_ZERO && !ev.first_edge && !one_shot_trig) |=> !irq1_r)
		else $error("Second interrupt raised at the wrap.");
	AST_IRQ1_EDGE: assert property (@(posedge clock) disable iff (srst)
		ev.first_edge |=> irq1_r) else $error("Second interrupt missing on first input edge.");
	AST_CC1_WRITE: assert property (@(posedge clock) disable iff (srst)
		(second_cc_we && running && !(crc_r[1] && ev.first_edge)) |=> cc1_r == $past(cc_wdata))
		else $error("Second register write lost while running.");
	AST_CAPTURE: assert property (@(posedge clock) disable iff (srst)
		(crc_r[1] && ev.first_edge) |=> cc1_r == $past(cnt_r)) else $error("Capture value wrong.");
	AST_IRQ0_ZERO: assert property (@(posedge clock) disable iff (srst)
		(wrap && cc0_r == timer_pkg::COUNT_ZERO && mode_r == timer_pkg::MODE_FREE) |=> !irq0_r)
		else $error("First interrupt raised at the wrap.");
	AST_START: assert property (@(posedge clock) disable iff (srst)
		(mode_we && mode_wdata != timer_pkg::MODE_STOP) |=> running) else $error("Counter did not start.");

	// First register at zero: its interrupt waits for the step off 0000H after a wrap.
	AST_IRQ0_ZERO_STEP: assert property (@(posedge clock) disable iff (srst)
		wrap_seq ##[1:TICK_GAP_MAX] first_zero_step_seq |=> irq0_r)
		else $error("First interrupt missing after wrap.");
	// A stop request halts counting and then holds the count at zero.
	AST_STOP_REQUEST: assert property (@(posedge clock) disable iff (srst)
		(mode_we && mode_wdata == timer_pkg::MODE_STOP) |=> !running ##1 cnt_r == timer_pkg::COUNT_ZERO)
		else $error("Counter did not stop.");
	// The wrap takes the counter to 0000H and remembers that it wrapped.
	AST_WRAP_ZERO: assert property (@(posedge clock) disable iff (srst)
		wrap |=> cnt_r == timer_pkg::COUNT_ZERO && wrapped_r)
		else $error("Counter did not wrap to zero.");
	// A one-shot trigger clears the counter and raises the second interrupt.
	AST_ONE_SHOT: assert property (@(posedge clock) disable iff (srst)
		(running && one_shot_trig) |=> cnt_r == timer_pkg::COUNT_ZERO && irq1_r)
		else $error("One-shot clear missing.");
	// A capture into the first register takes the live count.
	AST_CAPTURE_FIRST: assert property (@(posedge clock) disable iff (srst)
		(crc_r[0] && ev.second_edge) |=> cc0_r == $past(cnt_r))
		else $error("First capture value wrong.");
	// A set overflow flag stays set until software clears it.
	AST_OVF_HOLD: assert property (@(posedge clock) disable iff (srst)
		(ovf_r && !overflow_clr) |=> ovf_r)
		else $error("Overflow flag dropped without a clear.");
	// An edge selection of none never yields an event on the first input.
	AST_EDGE_NONE: assert property (@(posedge clock) disable iff (srst)
		(prm_r[timer_pkg::PRM_EDGE0_LSB +: 2] == timer_pkg::EDGE_NONE) |-> !ev.first_edge)
		else $error("Edge seen with no edge selected.");
	// No edge event reaches the counter logic while it is stopped.
	AST_EDGE_STOPPED: assert property (@(posedge clock) disable iff (srst)
		!running |-> !ev.first_edge && !ev.second_edge)
		else $error("Edge event while stopped.");
endmodule

// file: testbench/trigger_source.sv
// Drives one capture trigger pin high for HOLD clocks on each fire request.
module trigger_source #(
	parameter int HOLD = 4
) (
	input  wire logic clock,
	input  wire logic fire,
	output logic      pin
);
	timeunit 1ns;
	timeprecision 100ps;
	int   left  = 0;
	logic req_r = 1'b0;
	// Fire requests are taken at the rising edge, away from the falling edge on which the bench drives.
	always @(posedge clock) begin
		req_r <= fire;
	end
	// Pulse lasts longer than two count clocks so the capture is taken.
	always @(negedge clock) begin
		if (req_r)
			left <= HOLD;
		else if (left > 0)
			left <= left - 1;
	end
	assign pin = (left > 0);
endmodule

// file: testbench/test_timer_capture_compare_16bit.sv
module test_timer_capture_compare_16bit;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clock = 0, srst = 1, mode_we = 0, overflow_clr = 0, capture_ctrl_we = 0, prescaler_we = 0;
	logic        first_cc_we = 0, second_cc_we = 0, one_shot_trig = 0, fire0 = 0, fire1 = 0;
	logic [1:0]  mode_wdata = 0, capture_ctrl_wdata = 0, mode_control_reg;
	logic [7:0]  prescaler_wdata = 0;
	logic [15:0] cc_wdata = 0, count_register, first_capture_compare_reg, second_capture_compare_reg, c0;
	logic        first_trigger_input, second_trigger_input, overflow_flag, first_match_irq, second_match_irq;
	int          error_cnt = 0, samples_checked = 0, cycles = 0, irq2 = 0, irq_first = 0;
	logic [15:0] rows [3] = '{16'h0010, 16'h8000, 16'hFFFE};
	timer_capture_compare_16bit u_timer_capture_compare_16bit (.clock(clock), .srst(srst),
		.mode_wdata(mode_wdata), .mode_we(mode_we), .overflow_clr(overflow_clr),
		.capture_ctrl_wdata(capture_ctrl_wdata), .capture_ctrl_we(capture_ctrl_we),
		.prescaler_wdata(prescaler_wdata), .prescaler_we(prescaler_we), .cc_wdata(cc_wdata),
		.first_cc_we(first_cc_we), .second_cc_we(second_cc_we), .one_shot_trig(one_shot_trig),
		.first_trigger_input(first_trigger_input), .second_trigger_input(second_trigger_input),
		.count_register(count_register), .first_capture_compare_reg(first_capture_compare_reg),
		.second_capture_compare_reg(second_capture_compare_reg), .mode_control_reg(mode_control_reg),
		.overflow_flag(overflow_flag), .first_match_irq(first_match_irq), .second_match_irq(second_match_irq));
	trigger_source u_trigger_source0 (.clock(clock), .fire(fire0), .pin(first_trigger_input));
	trigger_source u_trigger_source1 (.clock(clock), .fire(fire1), .pin(second_trigger_input));
	// Free-running clock at 40 MHz.
	initial begin
		forever #12.5 clock = ~clock;
	end
	// Counts first and second interrupt pulses and cuts a hung run short.
	always @(posedge clock) begin
		cycles++;
		if (second_match_irq === 1'b1)
			irq2++;
		if (first_match_irq === 1'b1)
			irq_first++;
		if (cycles == 90000) begin
			error_cnt++;
			$display("wrong value at %0t: run timed out", $time);
			tally_and_finish();
		end
	end
	task automatic check16(input logic [15:0] got, input logic [15:0] exp, input string msg);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clock);
	endtask
	// One write strobe: 0 mode, 1 capture control, 2 prescaler, 3 first reg, 4 second reg.
	// An idle cycle follows so that back-to-back writes never lower and raise a strobe at once.
	task automatic wr(input int sel, input logic [15:0] d);
		case (sel)
			0: begin mode_wdata = d[1:0]; mode_we = 1; end
			1: begin capture_ctrl_wdata = d[1:0]; capture_ctrl_we = 1; end
			2: begin prescaler_wdata = d[7:0]; prescaler_we = 1; end
			3: begin cc_wdata = d; first_cc_we = 1; end
			default: begin cc_wdata = d; second_cc_we = 1; end
		endcase
		tick(1);
		{mode_we, capture_ctrl_we, prescaler_we, first_cc_we, second_cc_we} = 0;
		tick(1);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Main sequence: reset, table of running writes, then capture, stop, one-shot and wrap cases.
	initial begin
		tick(20);
		srst = 0;
		tick(1);
		check16({count_register[15:2], mode_control_reg}, 16'h0000, "reset state");
		$display("test reset done");
		wr(2, 16'h0009); // Rising edge on first input, second input ignored.
		wr(1, 16'h0002);
		wr(3, 16'hFFFF);
		check16(first_capture_compare_reg, 16'hFFFF, "first reg write");
		wr(0, 16'h0001); // Nonzero mode bits start counting.
		check16({14'h0000, mode_control_reg}, 16'h0001, "running mode");
		tick(3);
		c0 = count_register;
		tick(4);
		check16(count_register, c0 + 16'h0004, "count step");
		for (int i = 0; i < 3; i++) begin
			wr(4, rows[i]);
			check16(second_capture_compare_reg, rows[i], "second reg running write");
		end
		$display("test running writes done");
		irq2 = 0;
		c0 = count_register;
		fire0 = 1;
		tick(1);
		fire0 = 0;
		tick(8);
		check16(second_capture_compare_reg, c0 + 16'h0001, "capture");
		check16(16'(irq2), 16'h0001, "edge irq");
		wr(0, 16'h0000);
		tick(5);
		check16(count_register, 16'h0000, "stopped count");
		check16({14'h0000, mode_control_reg}, 16'h0000, "stopped mode");
		wr(2, 16'h000A);
		wr(0, 16'h0001);
		c0 = second_capture_compare_reg;
		fire0 = 1;
		tick(1);
		fire0 = 0;
		tick(8);
		check16(second_capture_compare_reg, c0, "edge none captured");
		$display("test capture done");
		irq2 = 0;
		one_shot_trig = 1;
		tick(1);
		one_shot_trig = 0;
		tick(1);
		check16(16'(count_register < 16'h0004), 16'h0001, "one-shot clear");
		check16(16'(irq2), 16'h0001, "one-shot irq");
		$display("test one-shot done");
		wr(4, 16'h0000);
		while (count_register < 16'hFFF0)
			tick(1);
		irq2 = 0;
		irq_first = 0;
		check16(16'(overflow_flag), 16'h0000, "flag early");
		tick(32);
		check16(16'(overflow_flag), 16'h0001, "overflow flag");
		check16(16'(irq_first), 16'h0001, "first match irq");
		check16(16'(irq2), 16'h0001, "zero compare irq");
		overflow_clr = 1;
		tick(1);
		overflow_clr = 0;
		tick(1);
		check16(16'(overflow_flag), 16'h0000, "flag clear");
		$display("test wrap done");
		tally_and_finish();
	end
endmodule
